// *** src/dsb_dram.sv ***
// ****************************************
// read data buffer
// ****************************************
module dsb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign in_ready_out  = (wr_ptr[PW] == rd_ptr[PW]) || (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]);
  assign out_valid_out = wr_ptr != rd_ptr;
  assign out_data_out  = store[rd_ptr[PW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      store[wr_ptr[PW-1:0]] <= in_data_in;
    end
  end

  // pointers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ****************************************
// dram device: command decode, banks, bursts
// ****************************************
module dsb_dram #(
  parameter int DQ_W   = 8,
  parameter int ROWB   = 3,   // stored row bits per bank
  parameter int COLB   = 4,   // stored column bits
  parameter int RD_LAT = 5,   // link clocks from read command to first beat, at least 2
  parameter int FIFO_D = 16
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  // link clock
  input  wire logic                  ck_t_in,
  input  wire logic                  ck_c_in,
  // command and address
  input  wire dsb_pkg::dsb_ca_s      ca_in,
  // data and strobe
  input  wire logic [DQ_W-1:0]       dq_in,
  output logic [DQ_W-1:0]            dq_out,
  output logic                       dq_oe_out,
  input  wire logic                  dqs_t_in,
  input  wire logic                  dqs_c_in,
  output logic                       dqs_t_out,
  output logic                       dqs_c_out,
  output logic                       dqs_oe_out,
  // configuration
  input  wire dsb_pkg::dsb_bl_e      bl_cfg_in,
  input  wire logic                  interleave_in,
  // status
  output logic [dsb_pkg::NBANK-1:0]  bank_open_out
);
  localparam int SW    = 4 + $bits(dsb_pkg::dsb_ca_s) + DQ_W;
  localparam int MEM_AW = dsb_pkg::BA_W + ROWB + COLB;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [SW-1:0] pin_m;
  logic [SW-1:0] pin_s;
  logic          ck_t_p;
  logic          dqs_t_p;

  // every pin passes two flops; a third stage of the clocks feeds edge finding only
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_m   <= '0;
      pin_s   <= '0;
      ck_t_p  <= 1'b0;
      dqs_t_p <= 1'b0;
    end else begin
      pin_m   <= {ck_t_in, ck_c_in, dqs_t_in, dqs_c_in, ca_in, dq_in};
      pin_s   <= pin_m;
      ck_t_p  <= pin_s[SW-1];
      dqs_t_p <= pin_s[SW-3];
    end
  end

  logic             ck_t_s;
  logic             ck_c_s;
  logic             dqs_t_s;
  logic             dqs_c_s;
  dsb_pkg::dsb_ca_s ca_s;
  logic [DQ_W-1:0]  dq_s;
  logic             ck_pos;
  logic             ck_neg;
  logic             dqs_rise;
  logic             dqs_fall;

  assign {ck_t_s, ck_c_s, dqs_t_s, dqs_c_s, ca_s, dq_s} = pin_s;
  // positive edge: true rises while complement is low
  assign ck_pos   = ck_t_s && !ck_t_p && !ck_c_s;
  assign ck_neg   = !ck_t_s && ck_t_p;
  assign dqs_rise = dqs_t_s && !dqs_t_p && !dqs_c_s;
  assign dqs_fall = !dqs_t_s && dqs_t_p;

  // ****************************************
  // command decode
  // ****************************************
  dsb_pkg::dsb_cmd_e cmd;
  logic              bc4_sel;

  always_comb begin
    cmd = dsb_pkg::CMD_NOP;
    if (ck_pos && !ca_s.cs_n) begin
      case ({ca_s.ras_n, ca_s.cas_n, ca_s.we_n})
        3'h3:    cmd = dsb_pkg::CMD_ACT;
        3'h5:    cmd = dsb_pkg::CMD_RD;
        3'h4:    cmd = dsb_pkg::CMD_WR;
        3'h2:    cmd = dsb_pkg::CMD_PRE;
        default: cmd = dsb_pkg::CMD_NOP;
      endcase
    end
  end

  // burst size: fixed setting or the chop pin on the fly
  always_comb begin
    case (bl_cfg_in)
      dsb_pkg::BL_FIXED4: bc4_sel = 1'b1;
      dsb_pkg::BL_OTF:    bc4_sel = !ca_s.addr[dsb_pkg::BC_BIT];
      default:            bc4_sel = 1'b0;
    endcase
  end

  dsb_pkg::dsb_burst_s new_burst;

  // bank and start column of a column access
  assign new_burst = '{ba: ca_s.ba, col: ca_s.addr[dsb_pkg::COL_W-1:0],
                       bc4: bc4_sel, ap: ca_s.addr[dsb_pkg::AP_BIT]};

  // column of beat i: sequential wraps in a nibble, interleave xors
  function automatic logic [dsb_pkg::COL_W-1:0] beat_col(
    input logic [dsb_pkg::COL_W-1:0] start,
    input logic [2:0]                i,
    input logic                      il
  );
    logic [2:0] low;
    low = il ? (start[2:0] ^ i) : {start[2] ^ i[2], 2'(start[1:0] + i[1:0])};
    return {start[dsb_pkg::COL_W-1:3], low};
  endfunction

  // ****************************************
  // banks
  // ****************************************
  logic [dsb_pkg::NBANK-1:0]  bank_open;
  logic [dsb_pkg::ADDR_W-1:0] bank_row [dsb_pkg::NBANK];
  logic [dsb_pkg::NBANK-1:0]  rd_close;
  logic [dsb_pkg::NBANK-1:0]  wr_close;

  // each bank keeps its own row, so one bank may open while another bursts
  for (genvar b = 0; b < dsb_pkg::NBANK; b++) begin : g_bank
    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        bank_open[b] <= 1'b0;
        bank_row[b]  <= '0;
      end else if (cmd == dsb_pkg::CMD_ACT && ca_s.ba == b) begin
        bank_open[b] <= 1'b1;
        bank_row[b]  <= ca_s.addr;
      end else if (cmd == dsb_pkg::CMD_PRE
                   && (ca_s.addr[dsb_pkg::AP_BIT] || ca_s.ba == b)) begin
        bank_open[b] <= 1'b0;
      end else if (rd_close[b] || wr_close[b]) begin
        bank_open[b] <= 1'b0;
      end
    end
  end

  assign bank_open_out = bank_open;

  // ****************************************
  // array
  // ****************************************
  logic [DQ_W-1:0] mem [2**MEM_AW];
  logic            mem_we;
  logic [MEM_AW-1:0] mem_wa;

  function automatic logic [MEM_AW-1:0] mem_addr(
    input dsb_pkg::dsb_burst_s bu,
    input logic [dsb_pkg::ADDR_W-1:0] row,
    input logic [2:0] i,
    input logic il
  );
    logic [dsb_pkg::COL_W-1:0] c;
    c = beat_col(bu.col, i, il);
    return {bu.ba, row[ROWB-1:0], c[COLB-1:0]};
  endfunction

  // write port; only the low row and column bits are stored
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem[mem_wa] <= dq_s;
    end
  end

  // ****************************************
  // read: fetch the whole burst into the buffer
  // ****************************************
  typedef enum logic [1:0] {RS_IDLE, RS_LAT, RS_PRE, RS_DATA} dsb_rs_e;

  dsb_rs_e             rs;
  dsb_pkg::dsb_burst_s rd_burst;
  logic [3:0]          fetch_cnt;
  logic [3:0]          beat_cnt;
  logic [7:0]          lat_cnt;
  logic                fetch_busy;
  logic                f_ready;
  logic                f_valid;
  logic [DQ_W-1:0]     f_data;
  logic                emit;
  logic [3:0]          rd_beats;
  logic [MEM_AW-1:0]   rd_addr;

  assign rd_beats = rd_burst.bc4 ? dsb_pkg::BEATS_BC4 : dsb_pkg::BEATS_BL8;
  assign rd_addr  = mem_addr(rd_burst, bank_row[rd_burst.ba], fetch_cnt[2:0], interleave_in);

  // fetch stalls while the buffer is full
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fetch_busy <= 1'b0;
      fetch_cnt  <= '0;
    end else if (cmd == dsb_pkg::CMD_RD && rs == RS_IDLE) begin
      fetch_busy <= 1'b1;
      fetch_cnt  <= '0;
    end else if (fetch_busy && f_ready) begin
      fetch_cnt  <= fetch_cnt + dsb_pkg::BEAT_ONE;
      fetch_busy <= (fetch_cnt + dsb_pkg::BEAT_ONE) != rd_beats;
    end
  end

  dsb_fifo #(
    .WIDTH (DQ_W),
    .DEPTH (FIFO_D)
  ) u_rd_fifo (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (fetch_busy),
    .in_ready_out  (f_ready),
    .in_data_in    (mem[rd_addr]),
    .out_valid_out (f_valid),
    .out_ready_in  (emit),
    .out_data_out  (f_data)
  );

  // a beat leaves on every link clock edge once the preamble is done
  assign emit = f_valid && ((rs == RS_PRE && ck_pos)
                || (rs == RS_DATA && (ck_pos || ck_neg) && beat_cnt != rd_beats));

  // ****************************************
  // read: pin side
  // ****************************************
  logic dqs_oe;

  // a read arriving while another is in flight is dropped
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rs        <= RS_IDLE;
      rd_burst  <= '0;
      lat_cnt   <= '0;
      beat_cnt  <= '0;
      dqs_oe    <= 1'b0;
      dq_out    <= '0;
      dqs_t_out <= 1'b0;
      dqs_c_out <= 1'b1;
      rd_close  <= '0;
    end else begin
      rd_close <= '0;
      case (rs)
        RS_IDLE: begin
          if (cmd == dsb_pkg::CMD_RD) begin
            rd_burst <= new_burst;
            lat_cnt  <= 8'(RD_LAT - 1);
            rs       <= RS_LAT;
          end
        end
        RS_LAT: begin
          if (ck_pos) begin
            if (lat_cnt == dsb_pkg::LAT_ONE) begin
              dqs_oe    <= 1'b1;  // preamble: strobe driven low
              dqs_t_out <= 1'b0;
              dqs_c_out <= 1'b1;
              rs        <= RS_PRE;
            end else begin
              lat_cnt <= lat_cnt - dsb_pkg::LAT_ONE;
            end
          end
        end
        RS_PRE: begin
          if (ck_pos) begin
            dq_out    <= f_data;  // first beat on first rising strobe
            dqs_t_out <= 1'b1;
            dqs_c_out <= 1'b0;
            beat_cnt  <= dsb_pkg::BEAT_ONE;
            rs        <= RS_DATA;
          end
        end
        default: begin
          if (ck_pos || ck_neg) begin
            if (beat_cnt == rd_beats) begin
              dqs_oe <= 1'b0;
              rs     <= RS_IDLE;
              if (rd_burst.ap) begin
                rd_close[rd_burst.ba] <= 1'b1;
              end
            end else begin
              dq_out    <= f_data;  // data and strobe change together
              dqs_t_out <= ck_pos;
              dqs_c_out <= !ck_pos;
              beat_cnt  <= beat_cnt + dsb_pkg::BEAT_ONE;
            end
          end
        end
      endcase
    end
  end

  assign dqs_oe_out = dqs_oe;
  assign dq_oe_out  = dqs_oe;

  // ****************************************
  // write: capture on strobe edges
  // ****************************************
  typedef enum logic [1:0] {WS_IDLE, WS_ARM, WS_DATA} dsb_ws_e;

  dsb_ws_e             ws;
  dsb_pkg::dsb_burst_s wr_burst;
  logic [3:0]          wr_cnt;
  logic [3:0]          wr_beats;

  assign wr_beats = wr_burst.bc4 ? dsb_pkg::BEATS_BC4 : dsb_pkg::BEATS_BL8;
  // strobe sits mid-eye, so data synced alongside it is stable at its edge
  assign mem_we   = (ws == WS_ARM && dqs_rise)
                    || (ws == WS_DATA && (dqs_rise || dqs_fall));
  assign mem_wa   = mem_addr(wr_burst, bank_row[wr_burst.ba], wr_cnt[2:0], interleave_in);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ws       <= WS_IDLE;
      wr_burst <= '0;
      wr_cnt   <= '0;
      wr_close <= '0;
    end else begin
      wr_close <= '0;
      case (ws)
        WS_IDLE: begin
          if (cmd == dsb_pkg::CMD_WR) begin
            wr_burst <= new_burst;
            wr_cnt   <= '0;
            ws       <= WS_ARM;
          end
        end
        default: begin
          if (mem_we) begin
            wr_cnt <= wr_cnt + dsb_pkg::BEAT_ONE;
            if (wr_cnt + dsb_pkg::BEAT_ONE == wr_beats) begin
              ws <= WS_IDLE;
              if (wr_burst.ap) begin
                wr_close[wr_burst.ba] <= 1'b1;
              end
            end else begin
              ws <= WS_DATA;
            end
          end
        end
      endcase
    end
  end
endmodule

// *** src/dsb_pkg.sv ***
// Function
// - data moves twice per link clock, once on each half period.
// - every access is one eight-beat core transfer seen as eight pin beats; chopped bursts here fetch and send four.
// - read data leaves with the strobe, data edges aligned to strobe edges.
// - command and address are taken when true clock rises, complement falls.
// - first write beat is taken on first rising strobe after write preamble.
// - first read beat goes out on first rising strobe after read preamble.
// - bank and address with activate select bank and row to open.
// - bank and address with read or write select bank and start column.
// - burst walks the programmed beat count in the programmed column order.
// - bursts of eight beats and chopped bursts of four are both supported.
// - auto precharge closes the row by itself when the burst ends.
// - reads come as fixed setting, four-beat chop or eight beats on the fly.
// - writes with auto precharge come in the same three burst forms.
// - banks open and close independently while another bank moves data.
package dsb_pkg;

  // ****************************************
  // pin widths and field positions
  // ****************************************
  localparam int BA_W   = 3;
  localparam int ADDR_W = 15;
  localparam int COL_W  = 10;
  localparam int NBANK  = 8;
  localparam int AP_BIT = 10;   // auto precharge, also precharge-all
  localparam int BC_BIT = 12;   // on-the-fly chop select, low means chop

  // ****************************************
  // burst sizes
  // ****************************************
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  localparam logic [3:0] BEAT_ONE  = 4'h1;
  localparam logic [7:0] LAT_ONE   = 8'h01;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    BL_FIXED8,
    BL_OTF,
    BL_FIXED4
  } dsb_bl_e;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_PRE
  } dsb_cmd_e;

  // command and address pins as sampled on one positive clock edge
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } dsb_ca_s;

  // one accepted column access
  typedef struct packed {
    logic [BA_W-1:0]  ba;
    logic [COL_W-1:0] col;
    logic             bc4;
    logic             ap;
  } dsb_burst_s;

endpackage

// *** verification/dsb_ctrl_model.sv ***
// ****************************************
// memory controller model
// ****************************************
module dsb_ctrl_model #(
  parameter int DQ_W = 8
) (
  // link clock
  output logic                  ck_t_out,
  output logic                  ck_c_out,
  // command and address
  output dsb_pkg::dsb_ca_s      ca_out,
  // write data and strobe
  output logic [DQ_W-1:0]       dq_out,
  output logic                  dqs_t_out,
  output logic                  dqs_c_out,
  output logic                  dqs_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  assign ck_c_out = ~ck_t_out;
  // no refresh is sent: a run is far shorter than one refresh interval and
  // the case stays at normal temperature, so the doubled hot rate never applies
  // free-running link clock, offset so no edge lands on a system clock edge
  initial begin
    ck_t_out = 1'b0;
    ca_out = {4'hF, 18'h00000};
    dq_out = '0;
    dqs_t_out = 1'b0;
    dqs_c_out = 1'b1;
    dqs_oe_out = 1'b0;
    #1.3;
    forever #32 ck_t_out = ~ck_t_out;
  end
  // command stands a full link clock centred on the rising edge
  task automatic send_cmd(input logic [3:0] ctl, input logic [2:0] ba, input logic [14:0] a);
    @(negedge ck_t_out);
    ca_out = {ctl, ba, a};
    @(negedge ck_t_out);
    ca_out = {4'hF, ~ba, ~a}; // deselected lines carry junk
  endtask
  // slow adds a whole link clock of preamble
  task automatic send_burst(input logic [DQ_W-1:0] d [8], input int n, input int slow);
    @(negedge ck_t_out);
    dqs_oe_out = 1'b1;
    dqs_t_out = 1'b0;
    dqs_c_out = 1'b1;
    #(32 + 64 * slow);
    for (int i = 0; i < n; i++) begin
      dq_out = d[i];
      #16 dqs_t_out = ~dqs_t_out; // edge in the middle of the eye
      dqs_c_out = ~dqs_t_out;
      #16;
    end
    // released lines show inverted last values, not a kind echo
    dqs_oe_out = 1'b0;
    dqs_t_out = ~dqs_t_out;
    dqs_c_out = ~dqs_t_out;
    dq_out = ~dq_out;
  endtask
endmodule

// *** verification/dsb_dram_monitor.sv ***
// ****************************************
// pin-level checker for the dram device
// ****************************************
module dsb_dram_monitor #(
  parameter int DQ_W = 8
) (
  // clock and reset
  input wire logic                      clk_in,
  input wire logic                      srst_in,
  // pins
  input wire dsb_pkg::dsb_ca_s          ca_in,
  input wire logic [DQ_W-1:0]           dq_out,
  input wire logic                      dq_oe_out,
  input wire logic                      dqs_t_out,
  input wire logic                      dqs_c_out,
  input wire logic                      dqs_oe_out,
  input wire logic [dsb_pkg::NBANK-1:0] bank_open_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // command pins delayed past the sync flops and bank flag register of the device
  dsb_pkg::dsb_ca_s ca_d1, ca_d2, ca_d3;
  always_ff @(posedge clk_in) begin
    ca_d1 <= ca_in;
    ca_d2 <= ca_d1;
    ca_d3 <= ca_d2;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // read preamble holds the strobe low, then the first beat rises
  sequence s_preamble;
    !dqs_t_out [*5];
  endsequence
  sequence s_first_beat;
    $rose(dqs_t_out);
  endsequence
  a_oe_pair_equal: assert property (dq_oe_out == dqs_oe_out)
    else $error("data and strobe enables differ");
  a_strobe_is_diff: assert property (dqs_c_out == !dqs_t_out)
    else $error("strobe pair not complementary");
  a_idle_strobe_low: assert property (!dqs_oe_out |-> !dqs_t_out)
    else $error("released strobe not low");
  a_data_with_strobe: assert property (
    $changed(dq_out) && dqs_oe_out && $past(dqs_oe_out) |-> $changed(dqs_t_out))
    else $error("read data moved off a strobe edge");
  // limitation: assumes a link clock no faster than ten system clocks
  a_beat_half_clock: assert property (
    $changed(dqs_t_out) && dqs_oe_out |=> $stable(dqs_t_out) [*4])
    else $error("strobe beat too short");
  a_preamble_then_beat: assert property (
    $rose(dqs_oe_out) |-> s_preamble ##[1:20] s_first_beat)
    else $error("read preamble or first beat misplaced");
  a_ends_after_low: assert property (
    $fell(dqs_oe_out) |-> !$past(dqs_t_out))
    else $error("read burst ended after an odd beat count");
  a_act_opens_bank: assert property (
    |(bank_open_out & ~$past(bank_open_out)) |-> !ca_d3.cs_n && !ca_d3.ras_n
      && ca_d3.cas_n && ca_d3.we_n && bank_open_out[ca_d3.ba])
    else $error("bank opened without activate");
endmodule

bind dsb_dram dsb_dram_monitor #(.DQ_W(DQ_W)) dsb_dram_monitor_inst (
  .clk_in(clk_in), .srst_in(srst_in), .ca_in(ca_in), .dq_out(dq_out),
  .dq_oe_out(dq_oe_out), .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out),
  .dqs_oe_out(dqs_oe_out), .bank_open_out(bank_open_out));

// *** verification/tb_top.sv ***
`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // wires and shadow state
  // ****************************************
  logic             clk_in = 1'b0;
  logic             srst_in = 1'b1;
  logic             ck_t, ck_c, dq_oe, ctl_t, ctl_c, ctl_oe, dqs_t, dqs_c, dqs_oe, il;
  logic [7:0]       dq_dev, ctl_dq, bank_open;
  dsb_pkg::dsb_ca_s ca;
  dsb_pkg::dsb_bl_e bl_cfg;
  logic [7:0]       shadow [1024];
  logic [7:0]       wd [8];
  logic [2:0]       row_of [8];
  int               bad_count, tests_run;

  always #2.5 clk_in = ~clk_in;

  // pin level is whoever drives it, else the model's released pattern
  dsb_dram #(.DQ_W(8), .RD_LAT(5)) dsb_dram_inst (
    .clk_in(clk_in), .srst_in(srst_in), .ck_t_in(ck_t), .ck_c_in(ck_c), .ca_in(ca),
    .dq_in(dq_oe ? dq_dev : ctl_dq), .dq_out(dq_dev), .dq_oe_out(dq_oe),
    .dqs_t_in(dqs_oe ? dqs_t : ctl_t), .dqs_c_in(dqs_oe ? dqs_c : ctl_c),
    .dqs_t_out(dqs_t), .dqs_c_out(dqs_c), .dqs_oe_out(dqs_oe),
    .bl_cfg_in(bl_cfg), .interleave_in(il), .bank_open_out(bank_open));
  dsb_ctrl_model dsb_ctrl_model_inst (
    .ck_t_out(ck_t), .ck_c_out(ck_c), .ca_out(ca), .dq_out(ctl_dq),
    .dqs_t_out(ctl_t), .dqs_c_out(ctl_c), .dqs_oe_out(ctl_oe));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [2:0] ord(logic [2:0] c, logic [2:0] i, logic lv);
    return lv ? c ^ i : {c[2] ^ i[2], c[1:0] + i[1:0]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // sel 0 watches the strobe enable, 1 the read strobe
  task automatic wait_sig(input int sel, input logic lvl, input int lim);
    int k;
    k = 0;
    while (((sel == 0) ? dqs_oe : dqs_t) !== lvl) begin
      @(negedge clk_in);
      k++;
      if (k > lim) begin
        bad_count++;
        $display("ERROR wait on %0d expected %0h seen timeout", sel, lvl);
        test_done();
      end
    end
  endtask

  task automatic act(input logic [2:0] ba, input logic [2:0] row);
    row_of[ba] = row;
    dsb_ctrl_model_inst.send_cmd(4'h3, ba, {12'h000, row}); // row opened first
    repeat (10) @(negedge clk_in);
  endtask

  task automatic wr_do(input logic [2:0] ba, input logic [2:0] col, input logic ap,
                       input logic a12, input int n, input int slow, input logic [7:0] base);
    for (int i = 0; i < 8; i++) wd[i] = base + 8'(i);
    dsb_ctrl_model_inst.send_cmd(4'h4, ba, {2'h0, a12, 1'b0, ap, 7'h00, col});
    dsb_ctrl_model_inst.send_burst(wd, n, slow);
    for (int i = 0; i < n; i++) shadow[{ba, row_of[ba], 1'b0, ord(col, i[2:0], il)}] = wd[i];
    repeat (10) @(negedge clk_in);
  endtask

  task automatic rd_chk(input logic [2:0] ba, input logic [2:0] col, input logic ap,
                        input logic a12, input int n);
    dsb_ctrl_model_inst.send_cmd(4'h5, ba, {2'h0, a12, 1'b0, ap, 7'h00, col});
    wait_sig(0, 1'b1, 200);
    // device alone drives data and strobe, and the preamble holds the strobe low
    `CHK("read drive and preamble", 3'h4, {dq_oe, ctl_oe, dqs_t})
    for (int i = 0; i < n; i++) begin
      wait_sig(1, ~i[0], 20);
      `CHK("read beat", shadow[{ba, row_of[ba], 1'b0, ord(col, i[2:0], il)}], dq_dev)
    end
    wait_sig(0, 1'b0, 12); // an overlong burst times out here
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    @(negedge clk_in);
    `CHK("bank flags", 8'h00, bank_open)
    `CHK("strobe enable", 1'b0, dqs_oe)
    `CHK("strobe pair", 2'h1, {dqs_t, dqs_c})
  endtask

  task automatic t_banks();
    act(3'h2, 3'h3);
    act(3'h5, 3'h6);
    `CHK("open banks", 8'h24, bank_open)
  endtask

  task automatic t_order();
    wr_do(3'h2, 3'h0, 1'b0, 1'b1, 8, 0, 8'h40);
    for (int lv = 0; lv < 2; lv++) begin
      @(negedge clk_in);
      il = lv[0];
      rd_chk(3'h2, 3'h5, 1'b0, 1'b1, 8);
    end
  endtask

  task automatic t_forms();
    dsb_pkg::dsb_bl_e fm [4] = '{dsb_pkg::BL_FIXED8, dsb_pkg::BL_FIXED4,
                                 dsb_pkg::BL_OTF, dsb_pkg::BL_OTF};
    wr_do(3'h5, 3'h0, 1'b0, 1'b0, 8, 1, 8'h80);
    for (int f = 0; f < 4; f++) begin
      @(negedge clk_in);
      bl_cfg = fm[f];
      rd_chk(3'h5, 3'h3, 1'b0, f[0], (f == 1 || f == 2) ? 4 : 8);
    end
  endtask

  task automatic t_auto_close();
    dsb_pkg::dsb_bl_e fm [3] = '{dsb_pkg::BL_FIXED8, dsb_pkg::BL_OTF, dsb_pkg::BL_OTF};
    for (int f = 0; f < 3; f++) begin
      @(negedge clk_in);
      bl_cfg = fm[f];
      act(3'h6, f[2:0]);
      wr_do(3'h6, 3'h0, 1'b1, f != 1, (f == 1) ? 4 : 8, 0, 8'hC0 + 8'(f * 16));
      `CHK("auto closed bank", 1'b0, bank_open[6])
    end
    act(3'h6, 3'h0);
    rd_chk(3'h6, 3'h0, 1'b1, 1'b1, 8);
    repeat (4) @(negedge clk_in);
    `CHK("banks after read", 8'h24, bank_open)
    dsb_ctrl_model_inst.send_cmd(4'h2, 3'h0, 15'h0400);
    repeat (10) @(negedge clk_in);
    `CHK("banks after close all", 8'h00, bank_open)
  endtask

  // reset in mid-run closes every bank, and activation works again after it
  task automatic t_midreset();
    act(3'h1, 3'h1);
    `CHK("bank before reset", 8'h02, bank_open)
    srst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    `CHK("banks after reset", 8'h00, bank_open)
    `CHK("strobe after reset", 3'h1, {dqs_oe, dqs_t, dqs_c})
    act(3'h3, 3'h2);
    `CHK("bank after reset", 8'h08, bank_open)
  endtask

  initial begin
    bl_cfg = dsb_pkg::BL_FIXED8;
    il = 1'b0;
    repeat (16) @(negedge clk_in);
    srst_in = 1'b0;
    t_reset();
    t_banks();
    t_order();
    t_forms();
    t_auto_close();
    t_midreset();
    test_done();
  end
endmodule
